// *** acs_pkg.sv ***
// Constants shared by the conversion sequencer and its
// successive-approximation engine.
// Assumes one system clock and a machine-cycle strobe.

package acs_pkg;

    // =========================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RESULT_HI = 8'h01;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h02;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h03;

    // =========================================================
    // Control/status field positions
    localparam int CHAN_LSB = 0;
    localparam int CHAN_MSB = 2;
    localparam int BUSY_BIT = 3;
    localparam int DONE_BIT = 4;
    localparam int EXT_EN_BIT = 5;
    localparam int RES_LO_LSB = 6;
    localparam int RES_LO_MSB = 7;

    // Interrupt status bit positions
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;

    // =========================================================
    // Reset values
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;

    // =========================================================
    // Timing in machine cycles
    localparam int INIT_MC = 2;
    localparam int SAMPLE_MC = 8;
    localparam int MC_PER_BIT = 4;
    localparam int RES_BITS = 10;
    localparam int TOTAL_MC = INIT_MC + SAMPLE_MC + MC_PER_BIT * RES_BITS;

    // =========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_INIT = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_CONVERT = 2'b11
    } acs_state_type;

endpackage

// *** acs_sar.sv ***
// Successive-approximation register for the converter.
// Assumes the comparator answer is valid whenever step is high.

`timescale 1ns/1ps

module acs_sar import acs_pkg::*; #(
    parameter int WIDTH = 10
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic step,
    input wire logic comp_hi,
    output logic [WIDTH-1:0] code_q,
    output logic [WIDTH-1:0] result
);

    // =========================================================
    // Elaboration check
    if (WIDTH < 2) begin : g_width_chk
        $error("acs_sar needs WIDTH of at least 2");
    end

    // Index of the bit now on trial
    logic [$clog2(WIDTH)-1:0] idx_q;
    // Trial code with the bit on trial resolved
    logic [WIDTH-1:0] resolved;
    // One-hot mask of the next trial bit
    logic [WIDTH-1:0] next_bit;

    // =========================================================
    // Resolve the trial bit from the comparator
    always_comb begin
        resolved = code_q;
        // Low comparator means the trial overshot the input
        if (!comp_hi) begin
            resolved[idx_q] = 1'b0;
        end
        next_bit = '0;
        if (idx_q != '0) begin
            next_bit[idx_q - 1'b1] = 1'b1;
        end
    end

    // Final word as it stands after the present step
    assign result = resolved;

    // =========================================================
    // Trial code and bit index
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            code_q <= '0;
            idx_q <= '0;
        end else if (load) begin
            // Start at mid-scale with the top bit on trial
            code_q <= {1'b1, {(WIDTH-1){1'b0}}};
            idx_q <= ($clog2(WIDTH))'(WIDTH - 1);
        end else if (step) begin
            code_q <= resolved | next_bit;
            if (idx_q != '0) begin
                idx_q <= idx_q - 1'b1;
            end
        end
    end

endmodule

// *** acs_top.sv ***
// Control logic of the 8-input 10-bit analog converter.
// Assumes a one-cycle machine-cycle strobe from the clock
// generator and a comparator answer from the analog core.
//
// The strobed register port and the register offsets were chosen for this implementation.

`timescale 1ns/1ps

module acs_top import acs_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_q,
    input wire logic mc_strobe,
    input wire logic external_start_pin,
    input wire logic sleep_req,
    input wire logic comp_hi,
    output logic [2:0] analog_select_q,
    output logic sample_en_q,
    output logic [RES_BITS-1:0] trial_code_q,
    output logic irq_q
);

    // =========================================================
    // Declarations
    // Sequencer state and its next value
    acs_state_type state_q;
    acs_state_type state_d;
    // Machine cycles spent in the present state; the bit number in conversion
    logic [5:0] cnt_q;
    // Machine cycles within the present result bit
    logic [1:0] phase_q;
    // Software start waiting for the cycle boundary
    logic pend_q;
    // Pin level at the previous machine-cycle end
    logic pin_prev_q;
    // Register fields
    logic [2:0] chan_q;
    logic ext_en_q;
    logic done_q;
    logic busy_q;
    logic [RES_BITS-1:0] result_q;
    // Interrupt status and mask
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    // Decoded accesses
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    // Done flag as the present write leaves it
    logic done_clr;
    logic done_after;
    // Start qualification
    logic quiet;
    logic sw_start;
    logic pin_rise;
    logic begin_conv;
    // Sequencer events
    logic init1_end;
    logic sample_end;
    logic bit_step;
    logic conv_end;
    logic abort;
    // Word from the approximation engine
    logic [RES_BITS-1:0] sar_result;

    // =========================================================
    // Register decode
    assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    assign wr_stat = reg_wr && (reg_addr == OFS_IRQ_STAT);
    assign wr_mask = reg_wr && (reg_addr == OFS_IRQ_MASK);
    // Writing zero to the done bit clears it; one has no effect
    assign done_clr = wr_ctrl && !reg_wdata[DONE_BIT];
    // Blocking looks at done after this write, so a write that
    // clears done and sets start is allowed to restart
    assign done_after = done_q && !done_clr;

    // =========================================================
    // Start qualification
    // Nothing running, nothing pending and not going to sleep
    assign quiet = (state_q == ST_IDLE) && !busy_q && !pend_q
        && !sleep_req;
    // Software start through the busy bit
    assign sw_start = wr_ctrl && reg_wdata[BUSY_BIT] && quiet
        && !done_after;
    // Rising pin edge judged only at machine-cycle ends
    assign pin_rise = mc_strobe && external_start_pin && !pin_prev_q
        && ext_en_q && quiet && !done_after;
    // Conversion opens on the boundary after the request
    assign begin_conv = (state_q == ST_IDLE) && !sleep_req
        && ((mc_strobe && pend_q) || pin_rise);

    // =========================================================
    // Sequencer events on machine-cycle ends, except abort, which is taken on any clock
    assign abort = sleep_req && (state_q != ST_IDLE || pend_q);
    assign init1_end = (state_q == ST_INIT) && mc_strobe
        && (cnt_q == 6'h00) && !sleep_req;
    assign sample_end = (state_q == ST_SAMPLE) && mc_strobe
        && (cnt_q == 6'(SAMPLE_MC - 1)) && !sleep_req;
    assign bit_step = (state_q == ST_CONVERT) && mc_strobe
        && (phase_q == 2'(MC_PER_BIT - 1)) && !sleep_req;
    // Last bit resolved: fifty machine cycles since the start
    assign conv_end = bit_step && (cnt_q == 6'(RES_BITS - 1));

    // =========================================================
    // Next-state logic
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (begin_conv) begin
                    state_d = ST_INIT;
                end
            end
            ST_INIT: begin
                // Second init cycle ends: sampling starts
                if (mc_strobe && cnt_q == 6'(INIT_MC - 1)) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (sample_end) begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (conv_end) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
        // Sleep overrides everything
        if (sleep_req) begin
            state_d = ST_IDLE;
        end
    end

    // =========================================================
    // State register
    // Reset leaves the sequencer idle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // =========================================================
    // Machine-cycle counters
    // Counting strobes, not clocks, keeps the timing fixed to
    // the core's machine cycle whatever its clock ratio
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 6'h00;
            phase_q <= 2'h0;
        end else if (state_d != state_q) begin
            // Every state starts counting from zero
            cnt_q <= 6'h00;
            phase_q <= 2'h0;
        end else if (mc_strobe) begin
            if (state_q == ST_CONVERT) begin
                // In conversion the counter holds the bit number
                phase_q <= phase_q + 2'h1;
                if (bit_step) begin
                    cnt_q <= cnt_q + 6'h01;
                end
            end else if (state_q != ST_IDLE) begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    // =========================================================
    // Pending software start
    // Cleared on the boundary that opens the conversion
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_q <= 1'b0;
        end else if (sleep_req) begin
            pend_q <= 1'b0;
        end else if (sw_start) begin
            pend_q <= 1'b1;
        end else if (begin_conv) begin
            pend_q <= 1'b0;
        end
    end

    // =========================================================
    // Pin history for edge detection
    // Updated only at cycle ends, so a pulse shorter than a
    // machine cycle may be missed; that is by design
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_prev_q <= 1'b0;
        end else if (mc_strobe) begin
            pin_prev_q <= external_start_pin;
        end
    end

    // =========================================================
    // Busy flag
    // Software can never clear it; only completion or sleep do
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
        end else if (sleep_req) begin
            busy_q <= 1'b0;
        end else if (init1_end) begin
            busy_q <= 1'b1;
        end else if (conv_end) begin
            busy_q <= 1'b0;
        end
    end

    // =========================================================
    // Completion flag
    // Completion wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_q <= 1'b0;
        end else if (conv_end) begin
            done_q <= 1'b1;
        end else if (done_clr) begin
            done_q <= 1'b0;
        end
    end

    // =========================================================
    // Result latch
    // Loaded only at a completion that finds done clear, so a
    // held result stays intact
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q <= RESULT_RST;
        end else if (conv_end && !done_q) begin
            result_q <= sar_result;
        end
    end

    // =========================================================
    // Channel field and external enable
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_q <= CHAN_RST;
            ext_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            ext_en_q <= reg_wdata[EXT_EN_BIT];
            // Channel frozen unless fully idle
            if (!done_q && !busy_q && state_q == ST_IDLE && !pend_q) begin
                chan_q <= reg_wdata[CHAN_MSB:CHAN_LSB];
            end
        end
    end

    // =========================================================
    // Analog-side outputs
    // The multiplexer follows the channel field one clock later
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_select_q <= CHAN_RST;
            sample_en_q <= 1'b0;
        end else begin
            analog_select_q <= chan_q;
            // Sample window spans the eight sampling cycles
            sample_en_q <= (state_d == ST_SAMPLE);
        end
    end

    // =========================================================
    // Approximation engine
    // Loaded as sampling ends, stepped once per result bit
    acs_sar #(
        .WIDTH(RES_BITS)
    ) u_sar (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .load(sample_end),
        .step(bit_step),
        .comp_hi(comp_hi),
        .code_q(trial_code_q),
        .result(sar_result)
    );

    // =========================================================
    // Interrupt status and mask
    // Hardware set wins over a write-one clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
        end else begin
            if (wr_mask) begin
                irq_mask_q <= reg_wdata[1:0];
            end
            if (conv_end) begin
                irq_stat_q[IRQ_DONE_BIT] <= 1'b1;
            end else if (wr_stat && reg_wdata[IRQ_DONE_BIT]) begin
                irq_stat_q[IRQ_DONE_BIT] <= 1'b0;
            end
            if (abort) begin
                irq_stat_q[IRQ_ABORT_BIT] <= 1'b1;
            end else if (wr_stat && reg_wdata[IRQ_ABORT_BIT]) begin
                irq_stat_q[IRQ_ABORT_BIT] <= 1'b0;
            end
        end
    end

    // =========================================================
    // Interrupt output
    // Registered, so it follows the status one cycle late
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // =========================================================
    // Read port
    // Data stand in the cycle after the strobe and only there
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= BYTE_RST;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFS_CTRL: begin
                    reg_rdata_q <= {result_q[1:0], ext_en_q, done_q,
                        busy_q, chan_q};
                end
                OFS_RESULT_HI: reg_rdata_q <= result_q[RES_BITS-1:2];
                OFS_IRQ_STAT: reg_rdata_q <= {6'h00, irq_stat_q};
                OFS_IRQ_MASK: reg_rdata_q <= {6'h00, irq_mask_q};
                default: begin
                    // Unmapped offsets read as zero
                    reg_rdata_q <= BYTE_RST;
                end
            endcase
        end else begin
            reg_rdata_q <= BYTE_RST;
        end
    end

endmodule

// *** acs_props.sv ***
// Port checker for the conversion sequencer, bound to acs_top.
// Assumes machine-cycle strobes at least three clocks apart.
`timescale 1ns/1ps
module acs_props import acs_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic mc_strobe,
    input wire logic external_start_pin,
    input wire logic sleep_req,
    input wire logic comp_hi,
    input wire logic [2:0] analog_select_q,
    input wire logic sample_en_q,
    input wire logic [RES_BITS-1:0] trial_code_q,
    input wire logic irq_q
);
    // ====================
    // Strobe counters per phase
    localparam int CONV_MC = MC_PER_BIT * RES_BITS;
    localparam int RUN_MC = TOTAL_MC - INIT_MC;
    logic [7:0] samp_q; // Strobes seen while sampling
    logic [7:0] conv_q; // Strobes since sampling ended
    logic [7:0] run_q; // Strobes since sampling began
    logic conv_on_q; // Bit resolution in flight
    logic run_on_q; // Sampling or resolution in flight
    // Sampling window length
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            samp_q <= 8'h00;
        end else if (!sample_en_q) begin
            samp_q <= 8'h00;
        end else begin
            samp_q <= samp_q + {7'h00, mc_strobe};
        end
    end
    // Phase counters; sleep drops them since an abort has no end count
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_on_q <= 1'b0;
            run_on_q <= 1'b0;
            conv_q <= 8'h00;
            run_q <= 8'h00;
        end else if (sleep_req || $rose(irq_q)) begin
            conv_on_q <= 1'b0;
            run_on_q <= 1'b0;
        end else begin
            if ($fell(sample_en_q)) begin
                conv_on_q <= 1'b1;
                conv_q <= 8'h00;
            end else if (conv_on_q && mc_strobe) begin
                conv_q <= conv_q + 8'h01;
            end
            if ($rose(sample_en_q)) begin
                run_on_q <= 1'b1;
                run_q <= 8'h00;
            end else if (run_on_q && mc_strobe) begin
                run_q <= run_q + 8'h01;
            end
        end
    end
    // ====================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Sampling output gone two clocks after sleep is seen
    sequence s_sleep_settle;
        ##2 !sample_en_q;
    endsequence
    a_read_slot_only:
    assert property (!reg_rd |=> reg_rdata_q == 8'h00) else $error("read data outside slot");
    a_sample_eight_mc:
    assert property ($fell(sample_en_q) && !$past(sleep_req) && !$past(sleep_req, 2)
        |-> int'(samp_q) == SAMPLE_MC) else $error("sampling window length wrong");
    a_bit_rate_four:
    assert property ($rose(irq_q) && conv_on_q |-> int'(conv_q) == CONV_MC)
        else $error("resolution strobe count wrong");
    a_total_run_length:
    assert property ($rose(irq_q) && run_on_q |-> int'(run_q) == RUN_MC)
        else $error("conversion length wrong");
    a_select_held:
    assert property (sample_en_q |-> $stable(analog_select_q)) else $error("channel moved");
    a_irq_has_cause:
    assert property ($rose(irq_q) |-> $past(mc_strobe, 2) || $past(sleep_req, 2)
        || $past(reg_wr, 2)) else $error("interrupt rose without cause");
    a_reset_quiet:
    assert property ($rose(arst_n) |-> !sample_en_q && !irq_q && trial_code_q == '0)
        else $error("outputs busy after reset");
    a_sleep_stops:
    assert property (sleep_req |-> s_sleep_settle) else $error("sampling kept in sleep");
endmodule

bind acs_top acs_props u_props (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .mc_strobe(mc_strobe), .external_start_pin(external_start_pin), .sleep_req(sleep_req),
    .comp_hi(comp_hi), .analog_select_q(analog_select_q), .sample_en_q(sample_en_q),
    .trial_code_q(trial_code_q), .irq_q(irq_q));

// *** acs_core_model.sv ***
// Analog core model: input mux, track-and-hold and comparator.
// Assumes the sequencer steps the trial code only after sampling.
`timescale 1ns/1ps
module acs_core_model import acs_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [9:0] level [8],
    input wire logic [2:0] analog_select_q,
    input wire logic sample_en_q,
    input wire logic [RES_BITS-1:0] trial_code_q,
    output logic comp_hi
);
    // ====================
    // Hold capacitor
    logic [9:0] held_q; // Voltage kept after sampling
    // Tracks the selected input only while sampling is on
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            held_q <= 10'h000;
        end else if (sample_en_q) begin
            held_q <= level[analog_select_q];
        end
    end
    // Comparator: high when the held input reaches the trial code
    assign comp_hi = held_q >= trial_code_q;
endmodule

// *** analog_conversion_sequencer_test.sv ***
// Self-checking bench for the conversion sequencer.
// Assumes acs_top, its package, checker and core model are compiled.
`timescale 1ns/1ps
module analog_conversion_sequencer_test;
    import acs_pkg::*;
    // ====================
    // Stimulus and observation
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic mc_strobe = 1'b0;
    logic external_start_pin = 1'b0;
    logic sleep_req = 1'b0;
    logic comp_hi;
    logic [7:0] reg_rdata_q;
    logic [2:0] analog_select_q;
    logic sample_en_q;
    logic [RES_BITS-1:0] trial_code_q;
    logic irq_q;
    logic [9:0] level [8]; // Analog input voltages per channel
    logic [1:0] div_q = 2'h0; // Machine-cycle divider
    logic rd_d = 1'b0; // Read data due this cycle
    logic [15:0] lfsr = 16'h97C6; // Random source, fixed start
    int n_errors = 0;
    int n_compared = 0;
    logic [15:0] exp_q [$]; // Pending reads: mask then value
    always #5 sys_clk = ~sys_clk;
    // One strobe every three clocks keeps a conversion at 150 clocks
    always @(posedge sys_clk) begin
        div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        mc_strobe <= (div_q == 2'h2);
        rd_d <= reg_rd;
    end
    acs_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .mc_strobe(mc_strobe), .external_start_pin(external_start_pin),
        .sleep_req(sleep_req), .comp_hi(comp_hi), .analog_select_q(analog_select_q),
        .sample_en_q(sample_en_q), .trial_code_q(trial_code_q), .irq_q(irq_q));
    acs_core_model u_core (.sys_clk(sys_clk), .arst_n(arst_n), .level(level),
        .analog_select_q(analog_select_q), .sample_en_q(sample_en_q),
        .trial_code_q(trial_code_q), .comp_hi(comp_hi));
    // ====================
    // Checking and reporting
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        n_compared++;
        if ((got & m) !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got & m, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Read data is judged in the one cycle it stands
    always @(negedge sys_clk) begin
        if (rd_d) begin
            check(reg_rdata_q, exp_q[0][7:0], exp_q[0][15:8]);
            void'(exp_q.pop_front());
        end
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // ====================
    // Bus tasks; every call starts just after a rising edge
    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d);
        cyc(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({m, e});
        cyc(1'b0, 1'b1, a, 8'h00);
        cyc(1'b0, 1'b0, a, 8'h00);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Interrupt is looked at on falling edges, where it has settled
    task automatic wait_irq();
        for (int i = 0; i < 400; i++) begin
            @(negedge sys_clk);
            if (irq_q === 1'b1) begin
                break;
            end
        end
        if (irq_q !== 1'b1) begin
            n_errors++;
            $display("MISMATCH t=%0t no completion", $time);
            final_report();
        end
        @(posedge sys_clk);
    endtask
    // Result readback, refused restart, then clearing of the flag
    task automatic finish_conv(input logic [2:0] ch, input logic ext);
        wait_irq();
        rd(OFS_CTRL, {level[ch][1:0], ext, 2'b10, ch}, 8'hFF);
        rd(OFS_RESULT_HI, level[ch][9:2], 8'hFF);
        wr(OFS_CTRL, {2'b00, ext, 2'b11, ch + 3'h1});
        idle(30);
        rd(OFS_CTRL, {level[ch][1:0], ext, 2'b10, ch}, 8'hFF);
        wr(OFS_CTRL, {2'b00, ext, 2'b00, ch});
        wr(OFS_IRQ_STAT, 8'h01);
        rd(OFS_IRQ_STAT, 8'h00, 8'h01);
        @(negedge sys_clk);
        check({7'h00, irq_q}, 8'h00, 8'h01);
        @(posedge sys_clk);
        rd(OFS_CTRL, {level[ch][1:0], ext, 2'b00, ch}, 8'hFF);
    endtask
    // ====================
    // Main sequence
    initial begin
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            level[k] = lfsr[9:0];
        end
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        rd(OFS_CTRL, 8'h00, 8'hFF);
        rd(OFS_RESULT_HI, 8'h00, 8'hFF);
        rd(8'h07, 8'h00, 8'hFF);
        wr(OFS_IRQ_MASK, 8'h01);
        $display("test reset done");
        // Software starts on every channel, with a restart tried while busy
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CTRL, {5'h00, 3'(c)});
            wr(OFS_CTRL, {5'h01, 3'(c)});
            idle(12);
            rd(OFS_CTRL, 8'h08, 8'h38);
            wr(OFS_CTRL, {5'h01, 3'(c) ^ 3'h1});
            finish_conv(3'(c), 1'b0);
        end
        $display("test software starts done");
        // Pin ignored while disabled, then a rising edge starts
        external_start_pin <= 1'b1;
        idle(30);
        external_start_pin <= 1'b0;
        rd(OFS_CTRL, 8'h00, 8'h18);
        wr(OFS_CTRL, 8'h25);
        idle(6);
        external_start_pin <= 1'b1;
        idle(15);
        external_start_pin <= 1'b0;
        finish_conv(3'h5, 1'b1);
        $display("test external start done");
        // Clearing the flag and starting in one write
        wr(OFS_CTRL, 8'h0A);
        wait_irq();
        wr(OFS_CTRL, 8'h0A);
        wr(OFS_IRQ_STAT, 8'h01);
        // Busy shows only after the second strobe of the start
        idle(6);
        rd(OFS_CTRL, 8'h08, 8'h18);
        finish_conv(3'h2, 1'b0);
        $display("test clear and start done");
        // Sleep aborts a running conversion; abort event masked until its mask bit is set
        wr(OFS_CTRL, 8'h0B);
        idle(20);
        sleep_req <= 1'b1;
        idle(4);
        sleep_req <= 1'b0;
        rd(OFS_CTRL, 8'h03, 8'h1F);
        rd(OFS_IRQ_STAT, 8'h02, 8'h03);
        @(negedge sys_clk);
        check({7'h00, irq_q}, 8'h00, 8'h01);
        @(posedge sys_clk);
        wr(OFS_IRQ_MASK, 8'h03);
        idle(2);
        @(negedge sys_clk);
        check({7'h00, irq_q}, 8'h01, 8'h01);
        @(posedge sys_clk);
        wr(OFS_IRQ_STAT, 8'h02);
        wr(OFS_IRQ_MASK, 8'h01);
        // A finished result survives sleep
        wr(OFS_CTRL, 8'h0B);
        wait_irq();
        sleep_req <= 1'b1;
        idle(4);
        sleep_req <= 1'b0;
        finish_conv(3'h3, 1'b0);
        $display("test sleep done");
        idle(4);
        final_report();
    end
endmodule
